/* File: rtl/pbfs_axil_slave.v */
// axi4-lite slave front end: handshakes, write strobe pulse and registered read answer
`timescale 1ns/100ps
`include "pbfs_defs.vh"

module pbfs_axil_slave #(
	parameter AW = 5
) (
	// clock and reset
	input wire sys_clk,
	input wire sys_rst,
	// write address and data
	input wire [AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// read address and data
	input wire [AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// register file side
	output wire wr_pulse,
	output reg [AW-1:0] wr_addr,
	output reg [31:0] wr_data,
	output reg [3:0] wr_strb,
	input wire wr_err,
	output wire [AW-1:0] rd_addr,
	input wire [31:0] rd_data,
	input wire rd_err
);

	reg aw_held_q;
	reg w_held_q;
	wire rd_go;

	// address and data may come in either order; each is held until both are in
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	assign wr_pulse = aw_held_q && w_held_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign rd_addr = s_axi_araddr;

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			wr_addr <= {AW{1'b0}};
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PBFS_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
			if (wr_pulse) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_err ? `PBFS_RESP_SLVERR : `PBFS_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `PBFS_RESP_OKAY;
		end else begin
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_err ? `PBFS_RESP_SLVERR : `PBFS_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // pbfs_axil_slave

/* File: rtl/pbfs_defs.vh */
// register map, field layout and reset values of the port b function select block
`ifndef PBFS_DEFS_VH
`define PBFS_DEFS_VH

`define PBFS_OFS_HIGH_FUNC 5'h00
`define PBFS_OFS_LOW_FUNC 5'h04
`define PBFS_OFS_DIRECTION 5'h08
`define PBFS_OFS_PIN_DATA 5'h0c
`define PBFS_OFS_EFF_ROLE 5'h10

`define PBFS_HIGH_FUNC_RESET 16'h0000
`define PBFS_LOW_FUNC_RESET 16'h0000
`define PBFS_DIRECTION_RESET 16'h0000
`define PBFS_PIN_DATA_RESET 16'h0000

`define PBFS_HIGH_FUNC_MASK 16'h000f
`define PBFS_LOW_FUNC_MASK_SMALL 16'hfffa
`define PBFS_PORT_MASK_LARGE 16'h03ff
`define PBFS_PORT_MASK_SMALL 16'h03fc

`define PBFS_PIN9_ROLE_LSB 2
`define PBFS_PIN8_ROLE_LSB 0

`define PBFS_ROLE_GPIO 2'h0
`define PBFS_ROLE_IRQ 2'h1
`define PBFS_ROLE_ADDR 2'h2
`define PBFS_ROLE_WAIT 2'h3

`define PBFS_RESP_OKAY 2'h0
`define PBFS_RESP_SLVERR 2'h2

`endif

/* File: rtl/pbfs_top.v */
// port b function select: role registers, direction and data registers, pin multiplexer
`timescale 1ns/100ps
`include "pbfs_defs.vh"

module pbfs_top #(
	parameter AW = 5,
	parameter SMALL_VARIANT = 0,
	parameter LOW_SC_OVERRIDE = 1
) (
	// clock and power-on reset
	input wire sys_clk,
	input wire sys_rst,
	// axi4-lite write channels
	input wire [AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read channels
	input wire [AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	// operating mode pin
	input wire single_chip_mode,
	// port pins
	input wire [9:0] pin_in,
	output reg [9:0] pin_out,
	output reg [9:0] pin_oe_n,
	// bus controller side
	input wire address_bit_21_out,
	input wire address_bit_20_out,
	output reg wait_request,
	// interrupt controller side, idle high
	output reg ext_interrupt_seven,
	output reg ext_interrupt_six,
	// peripheral side of the low pins
	input wire [7:0] alt_out,
	input wire [7:0] alt_drive,
	output reg [7:0] alt_in
);

	localparam [15:0] LOW_MASK = SMALL_VARIANT ? `PBFS_LOW_FUNC_MASK_SMALL : 16'hffff;
	localparam [15:0] PORT_MASK = SMALL_VARIANT ? `PBFS_PORT_MASK_SMALL : `PBFS_PORT_MASK_LARGE;
	localparam [9:0] PIN_PRESENT = PORT_MASK[9:0];

	// registers; only sys_rst (power-on) clears them, so watchdog, standby and sleep leave them alone
	reg [15:0] high_pin_function_reg_q;
	reg [15:0] low_pin_function_reg_q;
	reg [15:0] port_direction_reg_q;
	reg [15:0] pin_data_q;

	// synchronisers
	reg [9:0] pin_meta_q;
	reg [9:0] pin_sync_q;
	reg mode_meta_q;
	reg mode_sync_q;

	wire wr_pulse;
	wire [AW-1:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire [AW-1:0] rd_addr;
	reg [31:0] rd_data;
	reg rd_err;
	reg wr_err;
	wire [15:0] wr_bytes;

	wire [1:0] pin9_role_sel;
	wire [1:0] pin8_role_sel;
	reg [1:0] pin9_role_eff;
	reg [1:0] pin8_role_eff;
	wire [15:0] low_role_eff;
	wire [19:0] eff_role_word;
	wire [15:0] pin_level;

	pbfs_axil_slave #(
		.AW(AW)
	) u_bus (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_pulse(wr_pulse),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// mode pin and port pins come from outside the clock domain
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_meta_q <= 10'h000;
			pin_sync_q <= 10'h000;
			mode_meta_q <= 1'b0;
			mode_sync_q <= 1'b0;
		end else begin
			pin_meta_q <= pin_in;
			pin_sync_q <= pin_meta_q;
			mode_meta_q <= single_chip_mode;
			mode_sync_q <= mode_meta_q;
		end
	end

	// byte lanes 0 and 1 only; lanes 2 and 3 fall on bits that do not exist
	assign wr_bytes = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

	always @* begin
		wr_err = 1'b0;
		if (wr_addr == `PBFS_OFS_HIGH_FUNC) begin
			wr_err = 1'b0;
		end else if (wr_addr == `PBFS_OFS_LOW_FUNC) begin
			wr_err = 1'b0;
		end else if (wr_addr == `PBFS_OFS_DIRECTION) begin
			wr_err = 1'b0;
		end else if (wr_addr == `PBFS_OFS_PIN_DATA) begin
			wr_err = 1'b0;
		end else begin
			// the role status word is read-only, so writes to it are refused as well
			wr_err = 1'b1;
		end
	end

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			high_pin_function_reg_q <= `PBFS_HIGH_FUNC_RESET;
			low_pin_function_reg_q <= `PBFS_LOW_FUNC_RESET;
			port_direction_reg_q <= `PBFS_DIRECTION_RESET;
			pin_data_q <= `PBFS_PIN_DATA_RESET;
		end else if (wr_pulse) begin
			if (wr_addr == `PBFS_OFS_HIGH_FUNC) begin
				// reserved bits are never stored, so they read back as zero
				high_pin_function_reg_q <= (high_pin_function_reg_q & ~wr_bytes) |
					(wr_data[15:0] & wr_bytes & `PBFS_HIGH_FUNC_MASK);
			end else if (wr_addr == `PBFS_OFS_LOW_FUNC) begin
				low_pin_function_reg_q <= (low_pin_function_reg_q & ~wr_bytes) |
					(wr_data[15:0] & wr_bytes & LOW_MASK);
			end else if (wr_addr == `PBFS_OFS_DIRECTION) begin
				port_direction_reg_q <= (port_direction_reg_q & ~wr_bytes) |
					(wr_data[15:0] & wr_bytes & PORT_MASK);
			end else if (wr_addr == `PBFS_OFS_PIN_DATA) begin
				pin_data_q <= (pin_data_q & ~wr_bytes) | (wr_data[15:0] & wr_bytes & PORT_MASK);
			end
		end
	end

	// high pins: raw selection and single-chip override
	assign pin9_role_sel = high_pin_function_reg_q[`PBFS_PIN9_ROLE_LSB+1:`PBFS_PIN9_ROLE_LSB];
	assign pin8_role_sel = high_pin_function_reg_q[`PBFS_PIN8_ROLE_LSB+1:`PBFS_PIN8_ROLE_LSB];

	always @* begin
		pin9_role_eff = pin9_role_sel;
		if (pin9_role_sel == `PBFS_ROLE_WAIT) begin
			// reserved code has no function; the pin stays general purpose
			pin9_role_eff = `PBFS_ROLE_GPIO;
		end else if (mode_sync_q && pin9_role_sel == `PBFS_ROLE_ADDR) begin
			pin9_role_eff = `PBFS_ROLE_GPIO;
		end
	end

	always @* begin
		pin8_role_eff = pin8_role_sel;
		if (mode_sync_q && (pin8_role_sel == `PBFS_ROLE_ADDR || pin8_role_sel == `PBFS_ROLE_WAIT)) begin
			pin8_role_eff = `PBFS_ROLE_GPIO;
		end
	end

	// low pins: each two-bit field, zero meaning general purpose
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_low
			wire [1:0] sel;
			wire bus_role_blocked;
			assign sel = low_pin_function_reg_q[2*gi+1:2*gi];
			// the low fields only carry bus roles here, so single-chip mode keeps them as gpio on the large variant
			assign bus_role_blocked = (LOW_SC_OVERRIDE != 0) && (SMALL_VARIANT == 0) && mode_sync_q;
			assign low_role_eff[2*gi+1:2*gi] = (bus_role_blocked || !PIN_PRESENT[gi]) ?
				`PBFS_ROLE_GPIO : sel;

			always @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					pin_out[gi] <= 1'b0;
					pin_oe_n[gi] <= 1'b1;
					alt_in[gi] <= 1'b0;
				end else begin
					alt_in[gi] <= (low_role_eff[2*gi+1:2*gi] != `PBFS_ROLE_GPIO) ? pin_sync_q[gi] : 1'b0;
					if (!PIN_PRESENT[gi]) begin
						pin_out[gi] <= 1'b0;
						pin_oe_n[gi] <= 1'b1;
					end else if (low_role_eff[2*gi+1:2*gi] == `PBFS_ROLE_GPIO) begin
						pin_out[gi] <= pin_data_q[gi];
						pin_oe_n[gi] <= ~port_direction_reg_q[gi];
					end else begin
						pin_out[gi] <= alt_out[gi];
						pin_oe_n[gi] <= ~alt_drive[gi];
					end
				end
			end
		end
	endgenerate

	// pin 9 output stage
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_out[9] <= 1'b0;
			pin_oe_n[9] <= 1'b1;
			ext_interrupt_seven <= 1'b1;
		end else begin
			ext_interrupt_seven <= (pin9_role_eff == `PBFS_ROLE_IRQ) ? pin_sync_q[9] : 1'b1;
			case (pin9_role_eff)
				`PBFS_ROLE_ADDR: begin
					pin_out[9] <= address_bit_21_out;
					pin_oe_n[9] <= 1'b0;
				end
				`PBFS_ROLE_IRQ: begin
					pin_out[9] <= 1'b0;
					pin_oe_n[9] <= 1'b1;
				end
				default: begin
					pin_out[9] <= pin_data_q[9];
					pin_oe_n[9] <= ~port_direction_reg_q[9];
				end
			endcase
		end
	end

	// pin 8 output stage
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_out[8] <= 1'b0;
			pin_oe_n[8] <= 1'b1;
			ext_interrupt_six <= 1'b1;
			wait_request <= 1'b1;
		end else begin
			ext_interrupt_six <= (pin8_role_eff == `PBFS_ROLE_IRQ) ? pin_sync_q[8] : 1'b1;
			wait_request <= (pin8_role_eff == `PBFS_ROLE_WAIT) ? pin_sync_q[8] : 1'b1;
			case (pin8_role_eff)
				`PBFS_ROLE_ADDR: begin
					pin_out[8] <= address_bit_20_out;
					pin_oe_n[8] <= 1'b0;
				end
				`PBFS_ROLE_IRQ, `PBFS_ROLE_WAIT: begin
					pin_out[8] <= 1'b0;
					pin_oe_n[8] <= 1'b1;
				end
				default: begin
					pin_out[8] <= pin_data_q[8];
					pin_oe_n[8] <= ~port_direction_reg_q[8];
				end
			endcase
		end
	end

	// pin data reads the pin for inputs and the latch for driven pins
	assign pin_level = {6'h00, (pin_sync_q & ~port_direction_reg_q[9:0]) |
		(pin_data_q[9:0] & port_direction_reg_q[9:0])} & PORT_MASK;
	assign eff_role_word = {pin9_role_eff, pin8_role_eff, low_role_eff};

	always @* begin
		rd_data = 32'h00000000;
		rd_err = 1'b0;
		if (rd_addr == `PBFS_OFS_HIGH_FUNC) begin
			rd_data = {16'h0000, high_pin_function_reg_q & `PBFS_HIGH_FUNC_MASK};
		end else if (rd_addr == `PBFS_OFS_LOW_FUNC) begin
			rd_data = {16'h0000, low_pin_function_reg_q & LOW_MASK};
		end else if (rd_addr == `PBFS_OFS_DIRECTION) begin
			rd_data = {16'h0000, port_direction_reg_q};
		end else if (rd_addr == `PBFS_OFS_PIN_DATA) begin
			rd_data = {16'h0000, pin_level};
		end else if (rd_addr == `PBFS_OFS_EFF_ROLE) begin
			rd_data = {12'h000, eff_role_word};
		end else begin
			rd_err = 1'b1;
		end
	end

endmodule // pbfs_top

/* File: verif/pbfs_top_props.sv */
// checker for the port b function select top: bus handshakes, reset state, mode override
`timescale 1ns/100ps

module pbfs_top_props (
	// clock and reset
	input wire sys_clk,
	input wire sys_rst,
	// register bus
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// mode and pins
	input wire single_chip_mode,
	input wire [9:0] pin_oe_n,
	input wire wait_request,
	input wire ext_interrupt_seven,
	input wire ext_interrupt_six
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped or changed before bready");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped or changed before rready");
	aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write channel ready while response pending");
	ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address ready while answer pending");
	// both halves taken at one edge: register written at the next, bvalid seen one edge later
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write response late");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp != 2'h1)
		else $error("read answer late or bad response code");
	err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("error read returned nonzero data");
	sc_wait_a: assert property (single_chip_mode [*4] |-> wait_request)
		else $error("wait request active in single-chip mode");
	reset_idle_a: assert property (disable iff (1'b0) sys_rst |-> pin_oe_n == 10'h3ff && wait_request
		&& ext_interrupt_seven && ext_interrupt_six) else $error("pins not idle during reset");

	cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property ($fell(ext_interrupt_seven));
endmodule // pbfs_top_props

bind pbfs_top pbfs_top_props u_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .single_chip_mode(single_chip_mode), .pin_oe_n(pin_oe_n),
	.wait_request(wait_request), .ext_interrupt_seven(ext_interrupt_seven), .ext_interrupt_six(ext_interrupt_six));

/* File: verif/tb.sv */
// self-checking testbench for the port b function select top
`timescale 1ns/100ps

module tb;
	logic sys_clk = 0;
	logic sys_rst = 0;
	logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic single_chip_mode = 0, address_bit_21_out = 0, address_bit_20_out = 0;
	logic [9:0] pin_in = 0;
	logic [7:0] alt_out = 0, alt_drive = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [9:0] pin_out, pin_oe_n;
	wire wait_request, ext_interrupt_seven, ext_interrupt_six;
	wire [7:0] alt_in;
	int mismatches = 0, total_checks = 0, seed = 32'h1284d507, i;
	logic [1:0] c9, c8, e9, e8;
	logic [31:0] v;
	logic sc;
	wire [31:0] sm_rdata;
	wire [9:0] sm_oe_n;

	pbfs_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .single_chip_mode(single_chip_mode), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .address_bit_21_out(address_bit_21_out),
		.address_bit_20_out(address_bit_20_out), .wait_request(wait_request),
		.ext_interrupt_seven(ext_interrupt_seven), .ext_interrupt_six(ext_interrupt_six),
		.alt_out(alt_out), .alt_drive(alt_drive), .alt_in(alt_in));

	// smallest variant shares every input; only its read data and pin enables are looked at
	pbfs_top #(.SMALL_VARIANT(1)) dut_small (.sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(),
		.s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
		.s_axi_rdata(sm_rdata), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(s_axi_rready),
		.single_chip_mode(single_chip_mode), .pin_in(pin_in), .pin_out(), .pin_oe_n(sm_oe_n),
		.address_bit_21_out(address_bit_21_out), .address_bit_20_out(address_bit_20_out), .wait_request(),
		.ext_interrupt_seven(), .ext_interrupt_six(), .alt_out(alt_out), .alt_drive(alt_drive), .alt_in());

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic hang;
		mismatches++;
		$display("[FAIL] %0t wait limit used up", $time);
		end_sim();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// bready raised late on purpose so the response must stand unanswered
	task automatic wchk(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		bit got;
		got = 0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		for (n = 0; n < 40 && !got; n++) begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid && s_axi_bready) begin
				got = 1;
				s_axi_bready <= 0;
				chk({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
			end
			if (n == 2) s_axi_bready <= 1;
		end
		if (!got) hang();
	endtask

	task automatic rchk(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		bit got;
		got = 0;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		for (n = 0; n < 40 && !got; n++) begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid && s_axi_rready) begin
				got = 1;
				s_axi_rready <= 0;
				chk(s_axi_rdata, e, "read data");
				chk({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
			end
			if (n == 2) s_axi_rready <= 1;
		end
		if (!got) hang();
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// reserved pin 9 code and single-chip bus roles fall back to gpio
	function automatic logic [1:0] role9(input logic [1:0] c, input logic s);
		return ((c == 2'h2 && s) || c == 2'h3) ? 2'h0 : c;
	endfunction

	function automatic logic [1:0] role8(input logic [1:0] c, input logic s);
		return (s && c[1]) ? 2'h0 : c;
	endfunction

	initial begin
		#1 sys_rst = 1;
		repeat (6) @(posedge sys_clk);
		sys_rst <= 0;
		for (i = 0; i < 5; i++) rchk(5'(i * 4), 32'h0, 2'h0);
		$display("reset values done");
		for (i = 0; i < 16; i++) begin
			v = (i == 0) ? 32'hffffffff : $random(seed);
			wchk(5'h00, v, 2'h0);
			rchk(5'h00, {28'h0, v[3:0]}, 2'h0);
			wchk(5'h04, v, 2'h0);
			rchk(5'h04, {16'h0, v[15:0]}, 2'h0);
			chk(sm_rdata, {16'h0, v[15:0] & 16'hfffa}, "small low reg");
		end
		wchk(5'h14, v, 2'h2);
		wchk(5'h10, v, 2'h2);
		rchk(5'h14, 32'h0, 2'h2);
		$display("register access done");
		wchk(5'h04, 32'h0, 2'h0);
		for (i = 0; i < 32; i++) begin
			c9 = i[1:0];
			c8 = i[3:2];
			sc = i[4];
			pin_in <= 10'($random(seed));
			address_bit_21_out <= 1'($random(seed));
			address_bit_20_out <= 1'($random(seed));
			single_chip_mode <= sc;
			wchk(5'h00, {28'h0, c9, c8}, 2'h0);
			wt(4);
			e9 = role9(c9, sc);
			e8 = role8(c8, sc);
			rchk(5'h10, {12'h0, e9, e8, 16'h0}, 2'h0);
			chk(ext_interrupt_seven, (e9 == 2'h1) ? pin_in[9] : 1'b1, "irq seven");
			chk(ext_interrupt_six, (e8 == 2'h1) ? pin_in[8] : 1'b1, "irq six");
			chk(wait_request, (e8 == 2'h3) ? pin_in[8] : 1'b1, "wait request");
			chk({pin_oe_n[9], pin_oe_n[8]}, {e9 != 2'h2, e8 != 2'h2}, "address drive");
			if (e9 == 2'h2) chk(pin_out[9], address_bit_21_out, "address 21");
			if (e8 == 2'h2) chk(pin_out[8], address_bit_20_out, "address 20");
		end
		$display("pin roles done");
		single_chip_mode <= 0;
		wchk(5'h00, 32'h0, 2'h0);
		v = $random(seed);
		wchk(5'h08, 32'h3ff, 2'h0);
		wchk(5'h0c, {22'h0, v[9:0]}, 2'h0);
		wt(2);
		chk(pin_oe_n, 32'h0, "gpio drive enable");
		chk(pin_out, {22'h0, v[9:0]}, "gpio drive value");
		chk(sm_oe_n, 32'h003, "small pins absent");
		wchk(5'h08, 32'h0, 2'h0);
		wt(4);
		chk(pin_oe_n, 32'h3ff, "gpio input");
		rchk(5'h0c, {22'h0, pin_in}, 2'h0);
		$display("direction done");
		alt_out <= 8'($random(seed));
		alt_drive <= 8'($random(seed));
		pin_in <= 10'($random(seed));
		wchk(5'h04, 32'h5555, 2'h0);
		wt(4);
		rchk(5'h10, 32'h5555, 2'h0);
		chk(sm_rdata, 32'h5550, "small roles");
		chk(pin_out[7:0], alt_out, "alt value");
		chk(pin_oe_n[7:0], {~alt_drive}, "alt drive");
		chk(alt_in, pin_in[7:0], "alt input");
		single_chip_mode <= 1;
		wt(4);
		rchk(5'h10, 32'h0, 2'h0);
		// byte lane 1 masked off: only bits 7:0 may change
		s_axi_wstrb <= 4'h1;
		wchk(5'h04, 32'h0000aaaa, 2'h0);
		rchk(5'h04, 32'h000055aa, 2'h0);
		s_axi_wstrb <= 4'hf;
		$display("low roles done");
		wchk(5'h00, 32'h9, 2'h0);
		sys_rst <= 1;
		wt(2);
		sys_rst <= 0;
		rchk(5'h00, 32'h0, 2'h0);
		rchk(5'h04, 32'h0, 2'h0);
		$display("second reset done");
		end_sim();
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		hang();
	end
endmodule // tb
